/* File: hsc_top.v */
// Shared strobe and shift clock pin logic with its register slave
`timescale 1ns/1ps
`include "hsc_defs.vh"
module hsc_top (
    input wire clk,
    input wire rstn,
    input wire strobe_sclk_pin,
    input wire serial_in_pin,
    input wire device_select_n,
    input wire out_edge_select,
    input wire bus_muxing_select,
    input wire host_style_select,
    input wire [1:0] ctrl_mode_pin,
    input wire [7:0] ad_bus_in,
    output reg serial_out_pin,
    output reg serial_out_oe,
    output reg template_select_msb,
    output reg [4:0] latched_addr,
    output reg addr_latched_pulse,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready
);

    // ****************************************
    // Reset release
    // ****************************************
    reg rst_meta_r;
    reg rst_n_r;

    // Reset asserts at once and releases after two edges
    // Release is synchronous so every flop leaves reset on the same edge
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    wire [7:0] pins_s;
    wire [7:0] ad_s;

    // A level that changes near an edge is seen one cycle later, never split
    // Every pin passes two flops before use
    hsc_sync #(
        .W(8)
    ) u_sync_ctl (
        .clk(clk),
        .rst_n(rst_n_r),
        .d({strobe_sclk_pin, serial_in_pin, device_select_n, out_edge_select,
            bus_muxing_select, host_style_select, ctrl_mode_pin}),
        .q(pins_s)
    );

    // Shared bus lines are sampled the same way
    hsc_sync #(
        .W(8)
    ) u_sync_ad (
        .clk(clk),
        .rst_n(rst_n_r),
        .d(ad_bus_in),
        .q(ad_s)
    );

    wire strobe_s = pins_s[7];
    wire sdi_s = pins_s[6];
    wire cs_n_s = pins_s[5];
    wire oes_s = pins_s[4];
    wire mux_s = pins_s[3];
    wire style_s = pins_s[2];
    wire [1:0] mode_s = pins_s[1:0];

    // ****************************************
    // Synchroniser fill guard
    // ****************************************
    reg [1:0] fill_r;
    reg sync_ok_r;

    // Edges count only once the pin copies hold real levels, not reset zeros
    always @(posedge clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            fill_r <= 2'h0;
            sync_ok_r <= 1'b0;
        end
        else
        begin
            fill_r <= {fill_r[0], 1'b1};
            sync_ok_r <= fill_r[1];
        end
    end

    // ****************************************
    // Edge detection
    // ****************************************
    reg strobe_d_r;
    reg cs_n_d_r;

    // Previous levels of the strobe and chip select
    always @(posedge clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            strobe_d_r <= 1'b1;
            cs_n_d_r <= 1'b1;
        end
        else
        begin
            strobe_d_r <= strobe_s;
            cs_n_d_r <= cs_n_s;
        end
    end

    // Edge pulses and mode decode; the fill guard hides the false edges
    // that the reset zeros of the synchronisers would otherwise show
    wire clk_rise = sync_ok_r & strobe_s & ~strobe_d_r;
    wire clk_fall = sync_ok_r & ~strobe_s & strobe_d_r;
    wire cs_fall = sync_ok_r & ~cs_n_s & cs_n_d_r;
    wire in_ser = (mode_s == `HSC_MODE_SER);
    wire in_par = (mode_s == `HSC_MODE_PAR);
    wire in_hw = (mode_s == `HSC_MODE_HW);
    wire out_edge = oes_s ? clk_fall : clk_rise;
    wire ser_act = in_ser & ~cs_n_s & sync_ok_r;

    // ****************************************
    // Hardware mode template bit
    // ****************************************
    reg template_select_msb_nxt;

    // Pin level is the top template bit, held otherwise
    always @*
    begin
        template_select_msb_nxt = template_select_msb;
        if (in_hw)
            template_select_msb_nxt = strobe_s;
    end

    always @(posedge clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
            template_select_msb <= 1'b0;
        else
            template_select_msb <= template_select_msb_nxt;
    end

    // ****************************************
    // Multiplexed parallel address latch
    // ****************************************
    reg [7:0] latch_cnt_r;
    wire par_mux = in_par & mux_s;
    // Both host styles latch on the same falling strobe edge
    wire intel_latch = par_mux & style_s & clk_fall;
    wire moto_latch = par_mux & ~style_s & clk_fall;

    // Address holds until the next falling strobe edge in parallel mode with the shared bus
    // Lines 7..5 of the shared bus never reach the latch
    always @(posedge clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            latched_addr <= 5'h00;
            addr_latched_pulse <= 1'b0;
            latch_cnt_r <= 8'h00;
        end
        else
        begin
            addr_latched_pulse <= intel_latch | moto_latch;
            if (intel_latch)
                latched_addr <= ad_s[4:0];
            else if (moto_latch)
                latched_addr <= ad_s[4:0];
            if (intel_latch | moto_latch)
                latch_cnt_r <= latch_cnt_r + 8'h01;
        end
    end

    // ****************************************
    // Serial receive
    // ****************************************
    reg [7:0] rx_sh_r;
    reg [2:0] rx_cnt_r;
    reg [7:0] rx_data_r;

    // Input bits enter on the rising shift clock edge only
    // More than eight clocks in a frame wrap into the next received byte
    always @(posedge clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            rx_sh_r <= 8'h00;
            rx_cnt_r <= 3'h0;
            rx_data_r <= 8'h00;
        end
        else if (in_ser & cs_fall)
            rx_cnt_r <= 3'h0;
        else if (ser_act & clk_rise)
        begin
            rx_sh_r <= {rx_sh_r[6:0], sdi_s};
            rx_cnt_r <= rx_cnt_r + 3'h1;
            if (rx_cnt_r == 3'h7)
                rx_data_r <= {rx_sh_r[6:0], sdi_s};
        end
    end

    // ****************************************
    // Serial transmit
    // ****************************************
    wire [7:0] tx_data;
    wire oe_en;
    reg [7:0] tx_sh_r;
    reg tx_started_r;

    // Falling mode drives the first bit at select, rising mode at first edge
    // A select fall reloads the shifter, so a cut frame leaves nothing behind
    always @(posedge clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            tx_sh_r <= 8'h00;
            tx_started_r <= 1'b0;
            serial_out_pin <= 1'b0;
        end
        else if (in_ser & cs_fall)
        begin
            tx_sh_r <= tx_data;
            tx_started_r <= oes_s;
            if (oes_s)
                serial_out_pin <= tx_data[7];
        end
        else if (ser_act & out_edge)
        begin
            tx_started_r <= 1'b1;
            if (tx_started_r)
            begin
                tx_sh_r <= {tx_sh_r[6:0], 1'b0};
                serial_out_pin <= tx_sh_r[6];
            end
            else
                serial_out_pin <= tx_sh_r[7];
        end
    end

    // Output drives only while selected in serial mode
    always @(posedge clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
            serial_out_oe <= 1'b0;
        else
            serial_out_oe <= ser_act & oe_en;
    end

    // ****************************************
    // Register slave
    // ****************************************
    // Status packs latch count, mode, template bit and latched address
    wire [15:0] status;
    assign status = {latch_cnt_r, mode_s, template_select_msb, latched_addr};

    hsc_axil u_regs (
        .clk(clk),
        .rst_n(rst_n_r),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .tx_data_r(tx_data),
        .ctrl_oe_en_r(oe_en),
        .rx_data(rx_data_r),
        .status(status)
    );

endmodule // hsc_top

/* File: hsc_defs.vh */
// Constants for the host strobe and shift clock block
//
// Function
// - Hardware mode: shared pin level is top bit of template select.
// - Serial mode: output bit changes on falling clock if edge select high, else rising.
// - Serial mode: input bit sampled on rising clock edge always.
// - Intel multiplexed: latch bus bits 4..0 on strobe fall, ignore 7..5.
// - Motorola multiplexed: latch bus bits 4..0 on strobe fall, ignore 7..5.
// - Muxing select low means separate buses, high means shared bus.
// - Style select low means Motorola strobes, high means Intel strobes.
`ifndef HSC_DEFS_VH
`define HSC_DEFS_VH

// ****************************************
// Control modes on the mode pins
// ****************************************
`define HSC_MODE_HW 2'h0
`define HSC_MODE_SER 2'h1
`define HSC_MODE_PAR 2'h2

// ****************************************
// Register offsets
// ****************************************
`define HSC_OFS_TXDATA 4'h0
`define HSC_OFS_RXDATA 4'h4
`define HSC_OFS_STATUS 4'h8
`define HSC_OFS_CTRL 4'hC

// ****************************************
// Reset values and fields
// ****************************************
`define HSC_RST_TXDATA 8'h00
`define HSC_RST_CTRL 1'h1
`define HSC_CTRL_OE_BIT 0
`define HSC_ST_ADDR_LSB 0
`define HSC_ST_TS_BIT 5
`define HSC_ST_MODE_LSB 6
`define HSC_ST_CNT_LSB 8
`define HSC_ADDR_W 5
`define HSC_RESP_OKAY 2'h0
`define HSC_RESP_SLVERR 2'h2

`endif

/* File: hsc_sync.v */
// Two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module hsc_sync #(
    parameter W = 1
) (
    input wire clk,
    input wire rst_n,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_r;

    // First stage feeds only the second stage
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= {W{1'b0}};
            q <= {W{1'b0}};
        end
        else
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // hsc_sync

/* File: hsc_axil.v */
// AXI4-Lite slave holding the block's software registers
`timescale 1ns/1ps
`include "hsc_defs.vh"
module hsc_axil (
    input wire clk,
    input wire rst_n,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [7:0] tx_data_r,
    output reg ctrl_oe_en_r,
    input wire [7:0] rx_data,
    input wire [15:0] status
);
    reg [3:0] aw_r;
    reg aw_have_r;
    reg [31:0] w_r;
    reg [3:0] ws_r;
    reg w_have_r;

    // Word offset is mapped when it names one of the four registers
    function hsc_mapped;
        input [3:0] a;
        begin
            hsc_mapped = (a[1:0] == 2'h0);
        end
    endfunction

    // Write side: address and data are taken in either order
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `HSC_RESP_OKAY;
            aw_r <= 4'h0;
            aw_have_r <= 1'b0;
            w_r <= 32'h00000000;
            ws_r <= 4'h0;
            w_have_r <= 1'b0;
            tx_data_r <= `HSC_RST_TXDATA;
            ctrl_oe_en_r <= `HSC_RST_CTRL;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_r <= s_axi_awaddr;
                aw_have_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_r <= s_axi_wdata;
                ws_r <= s_axi_wstrb;
                w_have_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (aw_have_r && w_have_r && !s_axi_bvalid)
            begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= hsc_mapped(aw_r) ? `HSC_RESP_OKAY : `HSC_RESP_SLVERR;
                if (aw_r == `HSC_OFS_TXDATA && ws_r[0])
                    tx_data_r <= w_r[7:0];
                if (aw_r == `HSC_OFS_CTRL && ws_r[0])
                    ctrl_oe_en_r <= w_r[`HSC_CTRL_OE_BIT];
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Read side: answer one cycle after the address is taken
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `HSC_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= hsc_mapped(s_axi_araddr) ? `HSC_RESP_OKAY : `HSC_RESP_SLVERR;
            case (s_axi_araddr)
                `HSC_OFS_TXDATA: s_axi_rdata <= {24'h000000, tx_data_r};
                `HSC_OFS_RXDATA: s_axi_rdata <= {24'h000000, rx_data};
                `HSC_OFS_STATUS: s_axi_rdata <= {16'h0000, status};
                `HSC_OFS_CTRL: s_axi_rdata <= {31'h0, ctrl_oe_en_r};
                default: s_axi_rdata <= 32'h00000000;
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule // hsc_axil

/* File: hsc_top_monitor.sv */
// Checker for the pin behaviour of the host strobe and shift clock block
`timescale 1ns/1ps
module hsc_chk (
    input wire clk,
    input wire rstn,
    input wire strobe_sclk_pin,
    input wire device_select_n,
    input wire out_edge_select,
    input wire bus_muxing_select,
    input wire [1:0] ctrl_mode_pin,
    input wire serial_out_pin,
    input wire serial_out_oe,
    input wire template_select_msb,
    input wire [4:0] latched_addr,
    input wire addr_latched_pulse
);
    // ****************************************
    // Assertions on the pins
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // Serial output may not move in the half period after the sampling edge
    property p_out_edge;
        ctrl_mode_pin == 2'h1 && !device_select_n
            && (out_edge_select ? $rose(strobe_sclk_pin) : $fell(strobe_sclk_pin))
            |-> ##2 $stable(serial_out_pin) [*4];
    endproperty
    chk_tmpl_follow:
    assert property ((ctrl_mode_pin == 2'h0 && $stable(strobe_sclk_pin)) [*8]
        |-> template_select_msb == strobe_sclk_pin) else $error("template bit not following pin");
    chk_tmpl_hold:
    assert property ((ctrl_mode_pin != 2'h0) [*6] |-> $stable(template_select_msb))
        else $error("template bit moved outside hardware mode");
    chk_out_edge:
    assert property (p_out_edge) else $error("serial output moved on the wrong edge");
    chk_oe_idle:
    assert property ((ctrl_mode_pin != 2'h1 || device_select_n) [*6] |-> !serial_out_oe)
        else $error("serial output driven while not selected");
    chk_mux_latch:
    assert property (ctrl_mode_pin == 2'h2 && bus_muxing_select && $fell(strobe_sclk_pin)
        |-> ##[2:6] addr_latched_pulse) else $error("no address latch after strobe fall");
    chk_sep_ignore:
    assert property ((ctrl_mode_pin == 2'h2 && !bus_muxing_select) [*6] |-> !addr_latched_pulse)
        else $error("address latched with separate buses");
    chk_pulse_one:
    assert property (addr_latched_pulse |=> !addr_latched_pulse)
        else $error("latch pulse longer than one cycle");
    chk_addr_hold:
    assert property ($changed(latched_addr) |-> addr_latched_pulse)
        else $error("latched address changed without a latch");
    // Main scenarios reached
    cover property (addr_latched_pulse);
    cover property (serial_out_oe && !device_select_n);
    cover property ($rose(template_select_msb));
endmodule // hsc_chk

bind hsc_top hsc_chk hsc_chk_i (.clk, .rstn, .strobe_sclk_pin, .device_select_n,
    .out_edge_select, .bus_muxing_select, .ctrl_mode_pin, .serial_out_pin, .serial_out_oe,
    .template_select_msb, .latched_addr, .addr_latched_pulse);

/* File: hsc_host_model.sv */
// Host processor model driving the shared strobe, select, serial and bus pins
`timescale 1ns/1ps
module hsc_host (
    input wire clk,
    output logic strobe_sclk_pin,
    output logic serial_in_pin,
    output logic device_select_n,
    output logic [7:0] ad_bus_in,
    input wire serial_out_pin,
    input wire serial_out_oe
);
    // Idle levels: deselected, shift clock low
    initial
    begin
        strobe_sclk_pin = 1'h0;
        serial_in_pin = 1'h1;
        device_select_n = 1'h1;
        ad_bus_in = 8'hFF;
    end
    // Park the shared pin at a level
    task automatic park(input logic v);
        @(posedge clk);
        strobe_sclk_pin <= v;
        repeat (8) @(posedge clk);
    endtask
    // Address phase; with separate buses the strobe stays high
    task automatic addr_phase(input logic [7:0] ad, input logic mux);
        @(posedge clk);
        device_select_n <= 1'h0;
        ad_bus_in <= ad;
        repeat (4) @(posedge clk);
        strobe_sclk_pin <= !mux;
        repeat (5) @(posedge clk);
        ad_bus_in <= ~ad; // Released bus no longer shows the address
        strobe_sclk_pin <= 1'h1;
        repeat (8) @(posedge clk);
        device_select_n <= 1'h1;
        repeat (4) @(posedge clk);
    endtask
    // One framed byte, shift clock period 8 cycles, input changed on falling edges
    task automatic xfer(input logic es, input logic [7:0] din, output logic [7:0] dout,
        output logic oe_seen);
        oe_seen = 1'h0;
        dout = 8'h00;
        @(posedge clk);
        device_select_n <= 1'h0;
        serial_in_pin <= din[7];
        repeat (8) @(posedge clk);
        for (int i = 7; i >= 0; i--)
        begin
            strobe_sclk_pin <= 1'h1;
            repeat (3) @(posedge clk);
            if (es)
                dout[i] = serial_out_pin;
            oe_seen = oe_seen | serial_out_oe;
            @(posedge clk);
            strobe_sclk_pin <= 1'h0;
            serial_in_pin <= (i > 0) ? din[i - 1] : ~din[0];
            repeat (3) @(posedge clk);
            if (!es)
                dout[i] = serial_out_pin;
            @(posedge clk);
        end
        repeat (4) @(posedge clk);
        device_select_n <= 1'h1;
    endtask
endmodule // hsc_host

/* File: tb_top.sv */
// Self-checking bench for the host strobe and shift clock block
`timescale 1ns/1ps
`include "hsc_defs.vh"
module tb_top;
    logic clk = 1'h0;
    logic rstn = 1'h0;
    logic out_edge_select = 1'h0;
    logic bus_muxing_select = 1'h0;
    logic host_style_select = 1'h0;
    logic [1:0] ctrl_mode_pin = 2'h0;
    logic strobe_sclk_pin, serial_in_pin, device_select_n, serial_out_pin, serial_out_oe;
    logic template_select_msb, addr_latched_pulse;
    logic [7:0] ad_bus_in;
    logic [4:0] latched_addr;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [7:0] dout, cnt;
    logic oe;
    int failures = 0;
    int n_checks = 0;
    int cycles = 0;
    hsc_top hsc_top_i (.clk, .rstn, .strobe_sclk_pin, .serial_in_pin, .device_select_n,
        .out_edge_select, .bus_muxing_select, .host_style_select, .ctrl_mode_pin, .ad_bus_in,
        .serial_out_pin, .serial_out_oe, .template_select_msb, .latched_addr,
        .addr_latched_pulse, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    hsc_host hsc_host_i (.clk, .strobe_sclk_pin, .serial_in_pin, .device_select_n, .ad_bus_in,
        .serial_out_pin, .serial_out_oe);
    // ****************************************
    // Clock, timeout and shared tasks
    // ****************************************
    always #5 clk = ~clk;
    // Cut a hang short
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            failures++;
            close_out();
        end
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do
        begin
            @(posedge clk);
            if (s_axi_awready && s_axi_awvalid)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready && s_axi_wvalid)
                s_axi_wvalid <= 1'h0;
        end
        while (!s_axi_bvalid);
        r = s_axi_bresp;
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do
        begin
            @(posedge clk);
            if (s_axi_arready && s_axi_arvalid)
                s_axi_arvalid <= 1'h0;
        end
        while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    task automatic close_out();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ****************************************
    // Test sequence
    // ****************************************
    initial
    begin
        logic [7:0] txb [3];
        logic [7:0] rxb [3];
        logic [7:0] adb [2];
        txb = '{8'hA5, 8'h3C, 8'h81};
        rxb = '{8'h5A, 8'hC3, 8'h7E};
        adb = '{8'hE9, 8'h36};
        repeat (8) @(posedge clk);
        rstn <= 1'h1;
        repeat (4) @(posedge clk);
        axi_rd(`HSC_OFS_TXDATA, rd, rs);
        check("txdata reset", 32'h0, rd);
        axi_rd(`HSC_OFS_CTRL, rd, rs);
        check("ctrl reset", 32'h1, rd);
        axi_rd(4'h2, rd, rs);
        check("unaligned read resp", `HSC_RESP_SLVERR, rs);
        axi_wr(4'h6, 32'hFF, rs);
        check("unaligned write resp", `HSC_RESP_SLVERR, rs);
        axi_wr(`HSC_OFS_RXDATA, 32'hFF, rs);
        axi_rd(`HSC_OFS_RXDATA, rd, rs);
        check("rxdata read only", 32'h0, rd);
        $display("test registers done");
        for (int v = 1; v >= 0; v--)
        begin
            hsc_host_i.park(v[0]);
            check("template bit", v, template_select_msb);
            axi_rd(`HSC_OFS_STATUS, rd, rs);
            check("status template", v, rd[`HSC_ST_TS_BIT]);
        end
        $display("test hardware mode done");
        ctrl_mode_pin <= `HSC_MODE_SER;
        for (int k = 0; k < 3; k++)
        begin
            out_edge_select <= (k != 1);
            axi_wr(`HSC_OFS_TXDATA, {24'h0, txb[k]}, rs);
            axi_wr(`HSC_OFS_CTRL, {31'h0, k != 2}, rs);
            repeat (4) @(posedge clk);
            hsc_host_i.xfer(k != 1, rxb[k], dout, oe);
            check("output enable", k != 2, oe);
            if (k != 2)
                check("serial out byte", txb[k], dout);
            axi_rd(`HSC_OFS_RXDATA, rd, rs);
            check("received byte", rxb[k], rd);
        end
        axi_wr(`HSC_OFS_CTRL, 32'h1, rs);
        $display("test serial mode done");
        hsc_host_i.park(1'h1);
        ctrl_mode_pin <= `HSC_MODE_PAR;
        bus_muxing_select <= 1'h1;
        cnt = 8'h00;
        for (int s = 0; s < 2; s++)
        begin
            host_style_select <= s[0];
            repeat (6) @(posedge clk);
            hsc_host_i.addr_phase(adb[s], 1'h1);
            cnt = cnt + 8'h01;
            check("latched address", adb[s][4:0], latched_addr);
            axi_rd(`HSC_OFS_STATUS, rd, rs);
            check("status", {16'h0, cnt, 2'h2, 1'h0, adb[s][4:0]}, rd);
        end
        bus_muxing_select <= 1'h0;
        repeat (6) @(posedge clk);
        hsc_host_i.addr_phase(8'h1F, 1'h0);
        check("separate bus address", adb[1][4:0], latched_addr);
        $display("test parallel mode done");
        close_out();
    end
endmodule // tb_top
